// ===== aatp_completer.sv
// completing end: executes one atomic at a time on a small word memory
`timescale 1ns/1ps
`default_nettype none
module aatp_completer
#(
	parameter int WORDS = 16
)
(
	// clock and reset
	input  wire logic  mclk,
	input  wire logic  rst,
	// status
	output logic       busy,
	output logic       err_seen,
	// link
	aatp_if.completer  bus
);
	localparam int DW = aatp_pkg::DATA_W;
	localparam int AW = $clog2(WORDS);
	localparam int WB = $clog2(aatp_pkg::STRB_W);

	// refused at elaboration: the word index is a plain bit slice of the address
	if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0)
	begin : g_words_check
		$error("WORDS must be a power of two");
	end

	typedef enum logic [2:0]
	{
		CP_IDLE = 3'h0,
		CP_DATA = 3'h1,
		CP_READ = 3'h2,
		CP_RESP = 3'h3
	} aatp_cp_state_t;

	logic [DW-1:0] mem [WORDS];

	aatp_cp_state_t              state, next_state;
	logic [aatp_pkg::ID_W-1:0]   id_q, next_id;
	logic [aatp_pkg::ATOP_W-1:0] atop_q, next_atop;
	logic [AW-1:0]               widx, next_widx;
	logic [aatp_pkg::LEN_W:0]    wleft, next_wleft;
	logic [aatp_pkg::LEN_W:0]    rleft, next_rleft;
	logic                        bad, next_bad;
	logic [1:0]                  bresp_q, next_bresp;
	logic                        next_busy, next_err;
	// two-entry read buffer: holds original words, or zeros for a refused request, until the requester takes them
	logic [DW-1:0]               rbuf [2];
	logic [1:0]                  rcnt, next_rcnt;
	logic                        rhead, next_rhead;
	logic                        push, pop;
	logic [DW-1:0]               old_word, result;
	logic                        mem_we;

	function automatic logic [DW-1:0] swap_bytes(input logic [DW-1:0] v);
		logic [DW-1:0] r;
		r = '0;
		for (int i = 0; i < DW / 8; i++)
			r[i*8 +: 8] = v[DW-8-i*8 +: 8];
		return r;
	endfunction

	// operator on full words; byte order applied only to arithmetic
	function automatic logic [DW-1:0] apply_op(input logic [2:0] op, input logic big,
		input logic [DW-1:0] m, input logic [DW-1:0] s);
		logic [DW-1:0] a, b, r;
		a = big ? swap_bytes(m) : m;
		b = big ? swap_bytes(s) : s;
		r = '0;
		case (aatp_pkg::aatp_op_t'(op))
			aatp_pkg::OP_CLR:  return m & ~s;
			aatp_pkg::OP_EOR:  return m ^ s;
			aatp_pkg::OP_SET:  return m | s;
			aatp_pkg::OP_ADD:  r = a + b;
			aatp_pkg::OP_SMAX: r = ($signed(a) > $signed(b)) ? a : b;
			aatp_pkg::OP_SMIN: r = ($signed(a) < $signed(b)) ? a : b;
			aatp_pkg::OP_UMAX: r = (a > b) ? a : b;
			default:           r = (a < b) ? a : b;
		endcase
		return big ? swap_bytes(r) : r;
	endfunction

	// attribute check; a violation becomes an error response
	function automatic logic attr_bad(input logic [aatp_pkg::ATOP_W-1:0] t, input logic lk,
		input logic [aatp_pkg::SNOOP_W-1:0] sn, input logic [1:0] bu, input logic [aatp_pkg::LEN_W-1:0] ln);
		logic k;
		k = (t[5:4] == aatp_pkg::ATOP_K_STORE) || (t[5:4] == aatp_pkg::ATOP_K_LOAD)
			|| t == aatp_pkg::ATOP_SWAP || t == aatp_pkg::ATOP_CMP;
		if (!k || lk || sn != '0)
			return 1'b1;
		if (t == aatp_pkg::ATOP_CMP)
			return !(bu == aatp_pkg::BURST_INCR || bu == aatp_pkg::BURST_WRAP) || ln > 8'h01;
		return bu != aatp_pkg::BURST_INCR || ln != '0;
	endfunction

	assign pop           = bus.rvalid && bus.rready;
	assign bus.rvalid    = (rcnt != 2'h0);               // only filled after address taken
	assign bus.rdata     = rbuf[rhead];
	assign bus.rid       = id_q;
	assign bus.rresp     = bresp_q;
	assign bus.rlast     = (rcnt == 2'h1) && (rleft == '0);
	assign bus.awready   = (state == CP_IDLE);
	assign bus.wready    = (state == CP_DATA) && (wleft != '0) && (rcnt != 2'h2);
	assign bus.bvalid    = (state == CP_RESP);
	assign bus.bid       = id_q;
	assign bus.bresp     = bresp_q;                      // no outcome code
	assign old_word      = mem[widx];

	always_comb
	begin
		next_state = state;
		next_id    = id_q;
		next_atop  = atop_q;
		next_widx  = widx;
		next_wleft = wleft;
		next_rleft = rleft;
		next_bad   = bad;
		next_bresp = bresp_q;
		next_err   = err_seen;
		push       = 1'b0;
		mem_we     = 1'b0;
		result     = old_word;
		case (state)
			CP_IDLE:
				if (bus.awvalid)
				begin
					next_state = CP_DATA;
					next_id    = bus.awid;
					next_atop  = bus.awatop;
					next_widx  = bus.awaddr[WB +: AW];
					next_wleft = {1'b0, bus.awlen} + {{aatp_pkg::LEN_W{1'b0}}, 1'b1};
					next_rleft = aatp_pkg::read_beats(bus.awatop, bus.awlen);
					next_bad   = attr_bad(bus.awatop, bus.awlock, bus.awsnoop, bus.awburst, bus.awlen);
					next_bresp = next_bad ? aatp_pkg::RESP_SLVERR : aatp_pkg::RESP_OKAY;
					next_err   = err_seen | next_bad;
				end
			CP_DATA:
				// reads wait for writes: a beat reads the original only while read beats remain owed, and writes the result to memory unless refused
				if (bus.wvalid && bus.wready)
				begin
					next_wleft = wleft - {{aatp_pkg::LEN_W{1'b0}}, 1'b1};
					if (rleft != '0)
					begin
						push       = 1'b1;
						next_rleft = rleft - {{aatp_pkg::LEN_W{1'b0}}, 1'b1};
					end
					if (atop_q == aatp_pkg::ATOP_SWAP)
						result = bus.wdata;
					else if (atop_q == aatp_pkg::ATOP_CMP)
						result = old_word;
					else
						result = apply_op(atop_q[2:0], atop_q[aatp_pkg::ENDIAN_BIT], old_word, bus.wdata);
					mem_we = !bad;
					if (bus.wlast || next_wleft == '0)
						next_state = CP_READ;
				end
			CP_READ:
				if (rcnt == 2'h0 || (rcnt == 2'h1 && pop))
					next_state = CP_RESP;
			CP_RESP:
				if (bus.bready)
					next_state = CP_IDLE;
			default:
				next_state = CP_IDLE;
		endcase
		next_busy = (next_state != CP_IDLE);
		next_rcnt = rcnt + {1'b0, push} - {1'b0, pop};
		next_rhead = pop ? ~rhead : rhead;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state    <= CP_IDLE;
			id_q     <= '0;
			atop_q   <= aatp_pkg::ATOP_NONE;
			widx     <= '0;
			wleft    <= '0;
			rleft    <= '0;
			bad      <= 1'b0;
			bresp_q  <= aatp_pkg::RESP_OKAY;
			busy     <= 1'b0;
			err_seen <= 1'b0;
			rcnt     <= 2'h0;
			rhead    <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			id_q     <= next_id;
			atop_q   <= next_atop;
			widx     <= next_widx;
			wleft    <= next_wleft;
			rleft    <= next_rleft;
			bad      <= next_bad;
			bresp_q  <= next_bresp;
			busy     <= next_busy;
			err_seen <= next_err;
			rcnt     <= next_rcnt;
			rhead    <= next_rhead;
		end
	end

	// storage without reset; memory contents undefined until written
	always_ff @(posedge mclk)
	begin
		if (mem_we)
			mem[widx] <= result;
		if (push)
			rbuf[rhead ^ rcnt[0]] <= bad ? '0 : old_word;
	end
endmodule
`default_nettype wire

// ===== aatp_pkg.sv
// shared constants and types for the atomic transaction port
package aatp_pkg;
	localparam int ID_W      = 4;
	localparam int ADDR_W    = 16;
	localparam int DATA_W    = 64;
	localparam int STRB_W    = DATA_W / 8;
	localparam int LEN_W     = 8;
	localparam int SIZE_W    = 3;
	localparam int ATOP_W    = 6;
	localparam int SNOOP_W   = 4;
	localparam int ENDIAN_BIT = 3;

	localparam logic [ATOP_W-1:0] ATOP_NONE    = 6'h00;
	localparam logic [1:0]        ATOP_K_STORE = 2'h1;
	localparam logic [1:0]        ATOP_K_LOAD  = 2'h2;
	localparam logic [1:0]        ATOP_K_OTHER = 2'h3;
	localparam logic [ATOP_W-1:0] ATOP_SWAP    = 6'h30;
	localparam logic [ATOP_W-1:0] ATOP_CMP     = 6'h31;

	localparam logic [1:0] BURST_INCR = 2'h1;
	localparam logic [1:0] BURST_WRAP = 2'h2;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0]
	{
		OP_ADD  = 3'h0,
		OP_CLR  = 3'h1,
		OP_EOR  = 3'h2,
		OP_SET  = 3'h3,
		OP_SMAX = 3'h4,
		OP_SMIN = 3'h5,
		OP_UMAX = 3'h6,
		OP_UMIN = 3'h7
	} aatp_op_t;

	typedef enum logic [1:0]
	{
		K_NONE  = 2'h0,
		K_STORE = 2'h1,
		K_LOAD  = 2'h2,
		K_SWCMP = 2'h3
	} aatp_kind_t;

	// read beats owed: none for store, half the burst for multi-beat compare
	function automatic logic [LEN_W:0] read_beats(input logic [ATOP_W-1:0] atop, input logic [LEN_W-1:0] len);
		logic [LEN_W:0] n;
		n = {1'b0, len} + {{LEN_W{1'b0}}, 1'b1};
		if (atop[5:4] == ATOP_K_STORE || atop == ATOP_NONE)
			read_beats = '0;
		else if (atop == ATOP_CMP && len != '0)
			read_beats = n >> 1;
		else
			read_beats = n;
	endfunction
endpackage

// ===== aatp_if.sv
// write-address, write-data, read-data and response channels between the two ends
`timescale 1ns/1ps
`default_nettype none
interface aatp_if;
	logic                              awvalid;
	logic                              awready;
	logic [aatp_pkg::ID_W-1:0]         awid;
	logic [aatp_pkg::ADDR_W-1:0]       awaddr;
	logic [aatp_pkg::LEN_W-1:0]        awlen;
	logic [aatp_pkg::SIZE_W-1:0]       awsize;
	logic [1:0]                        awburst;
	logic                              awlock;
	logic [aatp_pkg::SNOOP_W-1:0]      awsnoop;
	logic [aatp_pkg::ATOP_W-1:0]       awatop;
	logic                              wvalid;
	logic                              wready;
	logic [aatp_pkg::DATA_W-1:0]       wdata;
	logic [aatp_pkg::STRB_W-1:0]       wstrb;
	logic                              wlast;
	logic                              rvalid;
	logic                              rready;
	logic [aatp_pkg::ID_W-1:0]         rid;
	logic [aatp_pkg::DATA_W-1:0]       rdata;
	logic [1:0]                        rresp;
	logic                              rlast;
	logic                              bvalid;
	logic                              bready;
	logic [aatp_pkg::ID_W-1:0]         bid;
	logic [1:0]                        bresp;

	modport requester
	(
		output awvalid, awid, awaddr, awlen, awsize, awburst, awlock, awsnoop, awatop,
		output wvalid, wdata, wstrb, wlast, rready, bready,
		input  awready, wready, rvalid, rid, rdata, rresp, rlast, bvalid, bid, bresp
	);
	modport completer
	(
		input  awvalid, awid, awaddr, awlen, awsize, awburst, awlock, awsnoop, awatop,
		input  wvalid, wdata, wstrb, wlast, rready, bready,
		output awready, wready, rvalid, rid, rdata, rresp, rlast, bvalid, bid, bresp
	);
endinterface
`default_nettype wire

// ===== aatp_requester.sv
// requesting end: issues one atomic request, streams write data, absorbs read data and response
`timescale 1ns/1ps
`default_nettype none
module aatp_requester
(
	// clock and reset
	input  wire logic                          mclk,
	input  wire logic                          rst,
	// user command
	input  wire logic                          cmd_valid,
	output logic                               cmd_ready,
	input  wire logic [aatp_pkg::ID_W-1:0]     cmd_id,
	input  wire logic [aatp_pkg::ADDR_W-1:0]   cmd_addr,
	input  wire logic [aatp_pkg::LEN_W-1:0]    cmd_len,
	input  wire logic [aatp_pkg::SIZE_W-1:0]   cmd_size,
	input  wire logic [aatp_pkg::ATOP_W-1:0]   cmd_atop,
	// user write data
	input  wire logic                          wd_valid,
	output logic                               wd_ready,
	input  wire logic [aatp_pkg::DATA_W-1:0]   wd_data,
	input  wire logic [aatp_pkg::STRB_W-1:0]   wd_strb,
	// user read data and completion
	output logic                               rd_valid,
	output logic [aatp_pkg::DATA_W-1:0]        rd_data,
	output logic                               done,
	output logic [1:0]                         done_resp,
	// link
	aatp_if.requester                          bus
);
	typedef enum logic [1:0]
	{
		RQ_IDLE = 2'h0,
		RQ_BUSY = 2'h1
	} aatp_rq_state_t;

	aatp_rq_state_t               state, next_state;
	logic                         aw_pend, next_aw_pend;
	logic [aatp_pkg::LEN_W:0]     wleft, next_wleft;
	logic [aatp_pkg::LEN_W:0]     rleft, next_rleft;
	logic                         b_got, next_b_got;
	logic                         next_cmd_ready;
	logic                         next_done;
	logic [1:0]                   next_done_resp;
	logic                         next_rd_valid;
	logic [aatp_pkg::DATA_W-1:0]  next_rd_data;
	logic [aatp_pkg::ID_W-1:0]    awid_q, next_awid;
	logic [aatp_pkg::ADDR_W-1:0]  awaddr_q, next_awaddr;
	logic [aatp_pkg::LEN_W-1:0]   awlen_q, next_awlen;
	logic [aatp_pkg::SIZE_W-1:0]  awsize_q, next_awsize;
	logic [1:0]                   awburst_q, next_awburst;
	logic [aatp_pkg::ATOP_W-1:0]  awatop_q, next_atop;
	logic [aatp_pkg::SIZE_W:0]    half_bit;

	// one transaction at a time keeps identifiers unique by construction
	assign bus.awvalid = aw_pend;
	assign bus.awid    = awid_q;
	assign bus.awaddr  = awaddr_q;
	assign bus.awlen   = awlen_q;
	assign bus.awsize  = awsize_q;
	assign bus.awburst = awburst_q;
	assign bus.awlock  = 1'b0;
	assign bus.awsnoop = '0;
	assign bus.awatop  = awatop_q;
	// write data flows independent of read data; read side always accepts
	assign bus.wvalid  = (state == RQ_BUSY) && (wleft != '0) && wd_valid;
	assign bus.wdata   = wd_data;
	assign bus.wstrb   = wd_strb;
	assign bus.wlast   = (wleft == {{aatp_pkg::LEN_W{1'b0}}, 1'b1});
	assign bus.rready  = 1'b1;
	assign bus.bready  = 1'b1;
	assign wd_ready    = (state == RQ_BUSY) && (wleft != '0) && bus.wready;

	always_comb
	begin
		next_state     = state;
		next_aw_pend   = aw_pend;
		next_wleft     = wleft;
		next_rleft     = rleft;
		next_b_got     = b_got;
		next_cmd_ready = 1'b0;
		next_done      = 1'b0;
		next_done_resp = done_resp;
		next_rd_valid  = 1'b0;
		next_rd_data   = rd_data;
		next_awid      = awid_q;
		next_awaddr    = awaddr_q;
		next_awlen     = awlen_q;
		next_awsize    = awsize_q;
		next_awburst   = awburst_q;
		next_atop      = awatop_q;
		half_bit       = {1'b0, cmd_size} - {{aatp_pkg::SIZE_W{1'b0}}, 1'b1};
		case (state)
			RQ_IDLE:
			begin
				next_cmd_ready = 1'b1;
				if (cmd_valid && cmd_ready)
				begin
					next_cmd_ready = 1'b0;
					next_state   = RQ_BUSY;
					next_aw_pend = 1'b1;
					next_awid    = cmd_id;
					next_awaddr  = cmd_addr;
					next_awlen   = cmd_len;
					next_awsize  = cmd_size;
					next_atop    = cmd_atop;
					next_awburst = aatp_pkg::BURST_INCR;
					// single-beat compare addressing the upper half must wrap
					if (cmd_atop == aatp_pkg::ATOP_CMP && cmd_len == '0 && cmd_size != '0
						&& cmd_addr[half_bit[aatp_pkg::SIZE_W-1:0]])
						next_awburst = aatp_pkg::BURST_WRAP;
					// multi-beat compare addressing the upper half must wrap
					if (cmd_atop == aatp_pkg::ATOP_CMP && cmd_len != '0
						&& cmd_addr[cmd_size] == 1'b1)
						next_awburst = aatp_pkg::BURST_WRAP;
					next_wleft   = {1'b0, cmd_len} + {{aatp_pkg::LEN_W{1'b0}}, 1'b1};
					next_rleft   = aatp_pkg::read_beats(cmd_atop, cmd_len);
					next_b_got   = 1'b0;
				end
			end
			RQ_BUSY:
			begin
				if (bus.awvalid && bus.awready)
					next_aw_pend = 1'b0;
				if (bus.wvalid && bus.wready)
					next_wleft = wleft - {{aatp_pkg::LEN_W{1'b0}}, 1'b1};
				if (bus.rvalid && rleft != '0)
				begin
					next_rleft    = rleft - {{aatp_pkg::LEN_W{1'b0}}, 1'b1};
					next_rd_valid = 1'b1;
					next_rd_data  = bus.rdata;  // caller compares original value itself
				end
				if (bus.bvalid)
				begin
					next_b_got     = 1'b1;
					next_done_resp = bus.bresp;
				end
				if (next_b_got && next_rleft == '0 && !next_aw_pend && next_wleft == '0)
				begin
					next_state = RQ_IDLE;
					next_done  = 1'b1;
				end
			end
			default:
				next_state = RQ_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state     <= RQ_IDLE;
			aw_pend   <= 1'b0;
			wleft     <= '0;
			rleft     <= '0;
			b_got     <= 1'b0;
			cmd_ready <= 1'b0;
			done      <= 1'b0;
			done_resp <= aatp_pkg::RESP_OKAY;
			rd_valid  <= 1'b0;
			rd_data   <= '0;
			awid_q    <= '0;
			awaddr_q  <= '0;
			awlen_q   <= '0;
			awsize_q  <= '0;
			awburst_q <= aatp_pkg::BURST_INCR;
			awatop_q  <= aatp_pkg::ATOP_NONE;
		end
		else
		begin
			state     <= next_state;
			aw_pend   <= next_aw_pend;
			wleft     <= next_wleft;
			rleft     <= next_rleft;
			b_got     <= next_b_got;
			cmd_ready <= next_cmd_ready;
			done      <= next_done;
			done_resp <= next_done_resp;
			rd_valid  <= next_rd_valid;
			rd_data   <= next_rd_data;
			awid_q    <= next_awid;
			awaddr_q  <= next_awaddr;
			awlen_q   <= next_awlen;
			awsize_q  <= next_awsize;
			awburst_q <= next_awburst;
			awatop_q  <= next_atop;
		end
	end
endmodule
`default_nettype wire

// ===== aatp_assertions.sv
// protocol checker watching the atomic link between the two ends
`timescale 1ns/1ps
`default_nettype none
module aatp_checker
(
	// clock and reset
	input wire logic                         mclk,
	input wire logic                         rst,
	// link
	input wire logic                         awvalid,
	input wire logic                         awready,
	input wire logic [aatp_pkg::ID_W-1:0]    awid,
	input wire logic [aatp_pkg::LEN_W-1:0]   awlen,
	input wire logic                         awlock,
	input wire logic [aatp_pkg::SNOOP_W-1:0] awsnoop,
	input wire logic [aatp_pkg::ATOP_W-1:0]  awatop,
	input wire logic                         wvalid,
	input wire logic                         wready,
	input wire logic                         wlast,
	input wire logic                         rvalid,
	input wire logic                         rready,
	input wire logic [aatp_pkg::ID_W-1:0]    rid,
	input wire logic                         rlast,
	input wire logic                         bvalid,
	input wire logic                         bready,
	input wire logic [aatp_pkg::ID_W-1:0]    bid,
	input wire logic [1:0]                   bresp
);
	logic                        seen_aw;
	logic                        seen_last;
	logic                        bad;
	logic [aatp_pkg::ID_W-1:0]   id_q;
	logic [aatp_pkg::ATOP_W-1:0] atop_q;
	logic [aatp_pkg::LEN_W-1:0]  len_q;
	logic [aatp_pkg::LEN_W:0]    r_cnt;
	logic [aatp_pkg::LEN_W:0]    r_exp;

	// owed read beats, worked out independently of the shared package helper
	always_comb
	begin
		r_exp = {1'b0, len_q} + 9'h001;
		if (atop_q[5:4] == 2'h1)
			r_exp = 9'h000;
		else if (atop_q == aatp_pkg::ATOP_CMP && len_q != 8'h00)
			r_exp = r_exp >> 1;
		// unknown codes, multi-beat store/load/swap and compare beyond two beats are refused
		bad = (atop_q[5:4] == 2'h0) || (atop_q[5:4] == 2'h3 && atop_q[5:1] != 5'h18)
			|| ((atop_q == aatp_pkg::ATOP_CMP) ? (len_q > 8'h01) : (len_q != 8'h00));
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			seen_aw <= 1'b0;
			seen_last <= 1'b0;
			id_q <= '0;
			atop_q <= '0;
			len_q <= '0;
			r_cnt <= '0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				seen_aw <= 1'b1;
				id_q <= awid;
				atop_q <= awatop;
				len_q <= awlen;
			end
			if (wvalid && wready && wlast)
				seen_last <= 1'b1;
			if (rvalid && rready)
				r_cnt <= r_cnt + 9'h001;
			if (bvalid && bready)
			begin
				seen_aw <= 1'b0;
				seen_last <= 1'b0;
				r_cnt <= '0;
			end
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	a_snoop_zero: assert property (awvalid |-> awsnoop == 4'h0) else $error("snoop not zero");
	a_lock_low: assert property (awvalid |-> !awlock) else $error("lock set");
	a_single_outstanding: assert property (awvalid |-> !seen_aw) else $error("overlapping request");
	a_read_after_aw: assert property (rvalid |-> seen_aw) else $error("read before address");
	a_resp_after_last: assert property (bvalid |-> seen_aw && seen_last) else $error("early response");
	a_read_id: assert property (rvalid |-> rid == id_q) else $error("read id differs");
	a_resp_id: assert property (bvalid |-> bid == id_q) else $error("resp id differs");
	a_read_count: assert property (bvalid |-> r_cnt == r_exp) else $error("read beat count");
	a_rlast_mark: assert property (rvalid && rlast |-> r_cnt + 9'h001 == r_exp) else $error("rlast misplaced");
	a_resp_bound: assert property ($rose(seen_last) |-> ##[0:16] bvalid) else $error("response late");
	a_single_resp: assert property (bvalid && bready |=> !bvalid) else $error("second response");
	a_error_resp: assert property (bvalid && bad |-> bresp == aatp_pkg::RESP_SLVERR) else $error("no error");
	a_ok_resp: assert property (bvalid && !bad |-> bresp == aatp_pkg::RESP_OKAY) else $error("bad resp");

	c_store: cover property (bvalid && bready && atop_q[5:4] == 2'h1);
	c_compare: cover property (bvalid && bready && atop_q == aatp_pkg::ATOP_CMP && len_q == 8'h01);
	c_error: cover property (bvalid && bready && bad);
endmodule
`default_nettype wire

// ===== axi_atomic_transaction_port_tb.sv
// self-checking bench: requester and completer joined back to back
`timescale 1ns/1ps
`default_nettype none
module axi_atomic_transaction_port_tb;
	logic                          mclk;
	logic                          rst;
	logic                          cmd_valid;
	logic                          cmd_ready;
	logic [aatp_pkg::ID_W-1:0]     cmd_id;
	logic [aatp_pkg::ADDR_W-1:0]   cmd_addr;
	logic [aatp_pkg::LEN_W-1:0]    cmd_len;
	logic [aatp_pkg::SIZE_W-1:0]   cmd_size;
	logic [aatp_pkg::ATOP_W-1:0]   cmd_atop;
	logic                          wd_valid;
	logic                          wd_ready;
	logic [aatp_pkg::DATA_W-1:0]   wd_data;
	logic                          rd_valid;
	logic [aatp_pkg::DATA_W-1:0]   rd_data;
	logic                          done;
	logic [1:0]                    done_resp;
	logic                          busy;
	logic                          err_seen;
	logic [63:0]                   mem1;
	logic [63:0]                   opd;
	int                            error_cnt;
	int                            comparisons;
	int                            cyc;

	aatp_if lnk();
	aatp_requester u_aatp_requester (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_id(cmd_id), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_size(cmd_size), .cmd_atop(cmd_atop),
		.wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data), .wd_strb(8'hFF), .rd_valid(rd_valid),
		.rd_data(rd_data), .done(done), .done_resp(done_resp), .bus(lnk.requester));
	aatp_completer #(.WORDS(16)) u_aatp_completer (.mclk(mclk), .rst(rst), .busy(busy), .err_seen(err_seen),
		.bus(lnk.completer));
	aatp_checker u_aatp_checker (.mclk(mclk), .rst(rst), .awvalid(lnk.awvalid), .awready(lnk.awready),
		.awid(lnk.awid), .awlen(lnk.awlen), .awlock(lnk.awlock), .awsnoop(lnk.awsnoop), .awatop(lnk.awatop),
		.wvalid(lnk.wvalid), .wready(lnk.wready), .wlast(lnk.wlast), .rvalid(lnk.rvalid), .rready(lnk.rready),
		.rid(lnk.rid), .rlast(lnk.rlast), .bvalid(lnk.bvalid), .bready(lnk.bready), .bid(lnk.bid),
		.bresp(lnk.bresp));

	always #12.5 mclk = ~mclk;

	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one whole transfer; an all-x expected value leaves the read data unchecked
	task automatic run(input logic [5:0] atop, input logic [15:0] addr, input logic [7:0] len, input logic [63:0] d0,
		input logic [63:0] d1, input int nrd, input logic [63:0] x0, input logic [1:0] resp);
		int k;
		int r;
		logic tk;
		logic ck;
		logic rv;
		logic dn;
		logic [63:0] rdd;
		logic [63:0] g0;
		logic [1:0] dr;
		k = 0;
		r = 0;
		dn = 1'b0;
		g0 = '0;
		cmd_atop = atop;
		cmd_addr = addr;
		cmd_len = len;
		cmd_id = cmd_id + 4'h1;
		cmd_valid = 1'b1;
		wd_valid = 1'b1;
		wd_data = d0;
		for (int n = 0; n < 200 && !dn; n++)
		begin
			@(negedge mclk);
			tk = wd_valid && wd_ready;
			ck = cmd_valid && cmd_ready;
			rv = rd_valid;
			rdd = rd_data;
			dn = done;
			dr = done_resp;
			@(posedge mclk);
			#1;
			if (ck)
				cmd_valid = 1'b0;
			if (tk)
			begin
				k++;
				wd_data = (k == 1) ? d1 : d0;
				wd_valid = (k <= int'(len));
			end
			if (rv)
			begin
				if (r == 0)
					g0 = rdd;
				r++;
			end
		end
		check("done", 1'b1, dn);
		check("read beats", nrd, r);
		check("resp", resp, dr);
		check("busy", 1'b0, busy);
		if (nrd > 0 && x0 !== 64'hx)
			check("rdata", x0, g0);
	endtask

	function automatic logic [63:0] opr(input logic [3:0] o, input logic [63:0] m, input logic [63:0] s);
		logic ar;
		logic [63:0] a;
		logic [63:0] b;
		logic [63:0] y;
		ar = o[3] && (o[2] || o[1:0] == 2'h0);
		a = m;
		b = s;
		if (ar)
		begin
			a = {<<8{m}};
			b = {<<8{s}};
		end
		case (o[2:0])
			3'h0: y = a + b;
			3'h1: y = a & ~b;
			3'h2: y = a ^ b;
			3'h3: y = a | b;
			3'h4: y = ($signed(a) > $signed(b)) ? a : b;
			3'h5: y = ($signed(a) < $signed(b)) ? a : b;
			3'h6: y = (a > b) ? a : b;
			default: y = (a < b) ? a : b;
		endcase
		if (ar)
			y = {<<8{y}};
		return y;
	endfunction

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			test_done();
		end
	end

	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		cmd_valid = 1'b0;
		wd_valid = 1'b0;
		cmd_id = '0;
		cmd_addr = '0;
		cmd_len = '0;
		cmd_size = 3'h3;
		cmd_atop = '0;
		wd_data = '0;
		error_cnt = 0;
		comparisons = 0;
		cyc = 0;
		repeat (10) @(posedge mclk);
		#1 rst = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		mem1 = 64'h8000_0000_0000_0003;
		run(6'h30, 16'h0008, 8'h00, mem1, mem1, 1, 64'hx, 2'h0);
		run(6'h30, 16'h0008, 8'h00, mem1, mem1, 1, mem1, 2'h0);
		for (int o = 0; o < 16; o++)
		begin
			opd = 64'h0123_4567_89AB_CDEF ^ {o[1:0], 62'h0};
			run({2'h2, o[3:0]}, 16'h0008, 8'h00, opd, opd, 1, mem1, 2'h0);
			mem1 = opr(o[3:0], mem1, opd);
		end
		for (int o = 0; o < 8; o++)
		begin
			run({3'h2, o[2:0]}, 16'h0008, 8'h00, ~mem1, ~mem1, 0, 64'hx, 2'h0);
			mem1 = opr({1'b0, o[2:0]}, mem1, ~mem1);
			run(6'h22, 16'h0008, 8'h00, 64'h0, 64'h0, 1, mem1, 2'h0);
		end
		run(6'h31, 16'h0008, 8'h00, mem1, 64'h5, 1, mem1, 2'h0);
		check("incr burst", aatp_pkg::BURST_INCR, lnk.awburst);
		run(6'h31, 16'h000C, 8'h00, 64'h5, mem1, 1, mem1, 2'h0);
		check("wrap burst", aatp_pkg::BURST_WRAP, lnk.awburst);
		run(6'h30, 16'h0010, 8'h00, 64'h77, 64'h77, 1, 64'hx, 2'h0);
		run(6'h31, 16'h0010, 8'h01, 64'h77, 64'h1, 1, 64'h77, 2'h0);
		check("err idle", 1'b0, err_seen);
		run(6'h31, 16'h0000, 8'h03, 64'h1, 64'h2, 2, 64'h0, aatp_pkg::RESP_SLVERR);
		run(6'h32, 16'h0008, 8'h00, 64'h1, 64'h1, 1, 64'h0, aatp_pkg::RESP_SLVERR);
		run(6'h20, 16'h0008, 8'h01, 64'h1, 64'h1, 2, 64'h0, aatp_pkg::RESP_SLVERR);
		check("err sticky", 1'b1, err_seen);
		run(6'h22, 16'h0008, 8'h00, 64'h0, 64'h0, 1, mem1, 2'h0);
		test_done();
	end
endmodule
`default_nettype wire
